/* File: design/mpc_pkg.sv */
/*
 * Constants of the motor parameter configuration bank: register offsets,
 * field positions, reset values, code meanings and timing counts.
 * Assumes a 125 MHz system clock and a two-wire serial register port with
 * 8-bit register pointers and 16-bit data words sent high byte first.
 */
package mpc_pkg;

	// ****************************************************************
	// register offsets
	// ****************************************************************
	localparam logic [7:0] TACH_RES_OFS = 8'h90;
	localparam logic [7:0] CONST_ADV_OFS = 8'h91;
	localparam logic [7:0] START_BRAKE_OFS = 8'h92;

	localparam logic [15:0] TACH_RES_RST = 16'h0000;
	localparam logic [15:0] CONST_ADV_RST = 16'h0000;
	localparam logic [15:0] START_BRAKE_RST = 16'h0000;

	// ****************************************************************
	// field positions of the first register
	// ****************************************************************
	localparam int DITHER_LSB = 14;
	localparam int TACH_SEL_LSB = 12;
	localparam int POLE_DIV_LSB = 8;
	localparam int CYCLE_ADJ_BIT = 7;
	localparam int RES_SHIFT_LSB = 4;
	localparam int RES_MANT_LSB = 0;

	// ****************************************************************
	// field positions of the second register
	// ****************************************************************
	localparam int CONST_RSVD_BIT = 15;
	localparam int KT_SHIFT_LSB = 12;
	localparam int KT_MANT_LSB = 8;
	localparam int ADV_MODE_BIT = 7;
	localparam int ADV_SHIFT_LSB = 4;
	localparam int ADV_MANT_LSB = 0;
	localparam logic [15:0] CONST_ADV_WMASK = 16'h7FFF;

	// ****************************************************************
	// code meanings
	// ****************************************************************
	localparam logic [1:0] TACH_ALWAYS = 2'h0;
	localparam logic [1:0] TACH_CLOSED_DLY = 2'h1;
	localparam logic [1:0] TACH_FIRST_OPEN = 2'h2;
	localparam logic [4:0] DITHER_PCT_0 = 5'h00;
	localparam logic [4:0] DITHER_PCT_1 = 5'h05;
	localparam logic [4:0] DITHER_PCT_2 = 5'h0A;
	localparam logic [4:0] DITHER_PCT_3 = 5'h0F;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int CLK_KHZ = 125000;
	localparam int TACH_DELAY_MS = 280;
	localparam int TACH_DELAY_CYCLES = TACH_DELAY_MS * CLK_KHZ;

	// ****************************************************************
	// serial port
	// ****************************************************************
	localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h52;

	typedef enum logic [3:0] {
		MPC_IDLE,
		MPC_ADDR,
		MPC_ADDR_ACK,
		MPC_PTR,
		MPC_PTR_ACK,
		MPC_WR_DATA,
		MPC_WR_ACK,
		MPC_RD_DATA,
		MPC_RD_ACK
	} mpc_state_t;

endpackage

/* File: design/mpc_tach_gen.sv */
/*
 * Tach output generator: divides the electrical phase signal by the pole
 * divider plus one and gates the result by the open-loop select code.
 * Assumes elec_phase, closed_loop and first_openloop are synchronous.
 */
`timescale 1ns/1ps
`default_nettype none
module mpc_tach_gen #(
	parameter int DELAY_CYCLES = mpc_pkg::TACH_DELAY_CYCLES
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic elec_phase,
	input wire logic closed_loop,
	input wire logic first_openloop,
	input wire logic [1:0] tach_openloop_select,
	input wire logic [3:0] tach_pole_divider,
	output logic tach_output
);
	localparam int CW = $clog2(DELAY_CYCLES + 1);

	logic elec_q;
	logic [3:0] edge_cnt;
	logic [CW-1:0] dly_cnt;
	logic dly_done;
	logic enable;
	logic elec_edge;

	// ****************************************************************
	// closed-loop delay and gating
	// ****************************************************************
	assign dly_done = (dly_cnt == CW'(DELAY_CYCLES));
	assign elec_edge = elec_phase ^ elec_q;

	// count time spent in closed loop, restart on leaving it
	always_ff @(posedge clk) begin
		if (sys_rst || !closed_loop) begin
			dly_cnt <= '0;
		end else if (!dly_done) begin
			dly_cnt <= dly_cnt + CW'(1);
		end
	end

	// choose the phases in which the tach pin runs
	always_comb begin
		case (tach_openloop_select)
			mpc_pkg::TACH_ALWAYS: enable = 1'b1;
			mpc_pkg::TACH_CLOSED_DLY: enable = closed_loop && dly_done;
			mpc_pkg::TACH_FIRST_OPEN: enable = closed_loop || first_openloop;
			default: enable = 1'b0; // reserved code keeps the pin quiet
		endcase
	end

	// ****************************************************************
	// divider
	// ****************************************************************
	// toggle after divider+1 phase edges so the rate is divided by n+1
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			elec_q <= 1'b0;
			edge_cnt <= 4'h0;
			tach_output <= 1'b0;
		end else begin
			elec_q <= elec_phase;
			if (!enable) begin
				edge_cnt <= 4'h0;
				tach_output <= 1'b0;
			end else if (elec_edge) begin
				if (edge_cnt >= tach_pole_divider) begin
					edge_cnt <= 4'h0;
					tach_output <= ~tach_output;
				end else begin
					edge_cnt <= edge_cnt + 4'h1;
				end
			end
		end
	end
endmodule // mpc_tach_gen
`default_nettype wire

/* File: design/mpc_config_regs.sv */
/*
 * Motor parameter configuration bank with its two-wire serial register
 * port, decoded fields for the motor control core and the tach output.
 * Assumes scl and sda_in are already synchronous to clk, and that the
 * pad combines sda_oe with a low drive level into the open-drain wire.
 */
`timescale 1ns/1ps
`default_nettype none
module mpc_config_regs #(
	parameter logic [6:0] DEV_ADDR = mpc_pkg::DEV_ADDR_DEFAULT,
	parameter int TACH_DELAY_CYCLES = mpc_pkg::TACH_DELAY_CYCLES,
	parameter int VW = 10
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic shadow_select,
	input wire logic [15:0] nv_tach_res,
	input wire logic [15:0] nv_const_adv,
	input wire logic [15:0] nv_start_brake,
	input wire logic elec_phase,
	input wire logic closed_loop,
	input wire logic first_openloop,
	input wire logic [VW-1:0] bemf_voltage,
	input wire logic [VW-1:0] supply_voltage,
	output logic tach_output,
	output logic [1:0] spread_dither_select,
	output logic [4:0] dither_span_pct,
	output logic cycle_adjust_select,
	output logic [10:0] phase_res_code,
	output logic [10:0] bemf_const_code,
	output logic advance_mode,
	output logic [10:0] advance_time,
	output logic [15:0] startup_brake_setup_out
);
	generate
		if (TACH_DELAY_CYCLES < 1 || VW < 2) begin : g_bad
			$error("mpc_config_regs: parameter out of range");
		end
	endgenerate

	logic [15:0] tach_resistance_setup;
	logic [15:0] motor_constant_advance_setup;
	logic [15:0] startup_brake_setup;
	logic [15:0] op_tach_res;
	logic [15:0] op_const_adv;
	logic [15:0] op_start_brake;

	mpc_pkg::mpc_state_t state;
	logic scl_q;
	logic sda_q;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;
	logic [7:0] shifter;
	logic [7:0] tx;
	logic [2:0] bit_cnt;
	logic byte_done;
	logic rw;
	logic hi_byte;
	logic nack;
	logic [7:0] ptr;
	logic [7:0] hold_hi;
	logic wr_stb;
	logic [15:0] wr_word;
	logic ack_phase;

	// ****************************************************************
	// read decode
	// ****************************************************************
	// reads always show the host-written copy, unmapped reads zero
	function automatic logic [7:0] rd_byte(input logic [7:0] a, logic hi);
		logic [15:0] w;
		w = 16'h0000;
		case (a)
			mpc_pkg::TACH_RES_OFS: w = tach_resistance_setup;
			mpc_pkg::CONST_ADV_OFS: w = motor_constant_advance_setup;
			mpc_pkg::START_BRAKE_OFS: w = startup_brake_setup;
			default: w = 16'h0000;
		endcase
		return hi ? w[15:8] : w[7:0];
	endfunction

	// ****************************************************************
	// bus line conditions
	// ****************************************************************
	assign scl_rise = scl && !scl_q;
	assign scl_fall = !scl && scl_q;
	assign start_seen = scl && scl_q && sda_q && !sda_in;
	assign stop_seen = scl && scl_q && !sda_q && sda_in;
	assign sda_out = 1'b0;
	assign ack_phase = state inside {mpc_pkg::MPC_ADDR_ACK,
		mpc_pkg::MPC_PTR_ACK, mpc_pkg::MPC_WR_ACK, mpc_pkg::MPC_RD_ACK};

	// open drain: pull low for acknowledges and zero read bits
	always_comb begin
		case (state)
			mpc_pkg::MPC_ADDR_ACK,
			mpc_pkg::MPC_PTR_ACK,
			mpc_pkg::MPC_WR_ACK: sda_oe = 1'b1;
			mpc_pkg::MPC_RD_DATA: sda_oe = !tx[7];
			default: sda_oe = 1'b0;
		endcase
	end

	// previous line levels for edge detection
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl;
			sda_q <= sda_in;
		end
	end

	// ****************************************************************
	// bit and byte framing
	// ****************************************************************
	// receive shifter and bit counter; acknowledge clocks are not counted
	always_ff @(posedge clk) begin
		if (sys_rst || start_seen) begin
			shifter <= 8'h00;
			bit_cnt <= 3'h0;
			byte_done <= 1'b0;
		end else if (scl_rise && !ack_phase) begin
			shifter <= {shifter[6:0], sda_in};
			bit_cnt <= bit_cnt + 3'h1;
			byte_done <= (bit_cnt == 3'h7);
		end else if (scl_fall && byte_done) begin
			byte_done <= 1'b0;
		end
	end

	// ****************************************************************
	// transfer sequencer
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state <= mpc_pkg::MPC_IDLE;
			rw <= 1'b0;
			hi_byte <= 1'b1;
			nack <= 1'b0;
			ptr <= 8'h00;
			hold_hi <= 8'h00;
			tx <= 8'hFF;
			wr_stb <= 1'b0;
			wr_word <= 16'h0000;
		end else begin
			wr_stb <= 1'b0;
			if (start_seen) begin
				state <= mpc_pkg::MPC_ADDR;
				hi_byte <= 1'b1;
			end else if (stop_seen) begin
				state <= mpc_pkg::MPC_IDLE;
			end else begin
				case (state)
					mpc_pkg::MPC_IDLE: state <= mpc_pkg::MPC_IDLE;
					mpc_pkg::MPC_ADDR: begin
						if (scl_fall && byte_done) begin
							rw <= shifter[0];
							if (shifter[7:1] == DEV_ADDR) begin
								state <= mpc_pkg::MPC_ADDR_ACK;
							end else begin
								state <= mpc_pkg::MPC_IDLE;
							end
						end
					end
					mpc_pkg::MPC_ADDR_ACK: begin
						if (scl_fall) begin
							if (rw) begin
								tx <= rd_byte(ptr, 1'b1);
								hi_byte <= 1'b1;
								state <= mpc_pkg::MPC_RD_DATA;
							end else begin
								state <= mpc_pkg::MPC_PTR;
							end
						end
					end
					mpc_pkg::MPC_PTR: begin
						if (scl_fall && byte_done) begin
							ptr <= shifter;
							state <= mpc_pkg::MPC_PTR_ACK;
						end
					end
					mpc_pkg::MPC_PTR_ACK: begin
						if (scl_fall) begin
							hi_byte <= 1'b1;
							state <= mpc_pkg::MPC_WR_DATA;
						end
					end
					mpc_pkg::MPC_WR_DATA: begin
						if (scl_fall && byte_done) begin
							if (hi_byte) begin
								hold_hi <= shifter;
							end else begin
								wr_word <= {hold_hi, shifter};
								wr_stb <= 1'b1;
							end
							state <= mpc_pkg::MPC_WR_ACK;
						end
					end
					mpc_pkg::MPC_WR_ACK: begin
						if (scl_fall) begin
							if (!hi_byte) begin
								ptr <= ptr + 8'h01;
							end
							hi_byte <= !hi_byte;
							state <= mpc_pkg::MPC_WR_DATA;
						end
					end
					mpc_pkg::MPC_RD_DATA: begin
						if (scl_fall && byte_done) begin
							tx <= 8'hFF;
							state <= mpc_pkg::MPC_RD_ACK;
						end else if (scl_fall) begin
							tx <= {tx[6:0], 1'b1};
						end
					end
					mpc_pkg::MPC_RD_ACK: begin
						if (scl_rise) begin
							nack <= sda_in;
						end else if (scl_fall) begin
							if (nack) begin
								state <= mpc_pkg::MPC_IDLE;
							end else if (hi_byte) begin
								tx <= rd_byte(ptr, 1'b0);
								hi_byte <= 1'b0;
								state <= mpc_pkg::MPC_RD_DATA;
							end else begin
								tx <= rd_byte(ptr + 8'h01, 1'b1);
								ptr <= ptr + 8'h01;
								hi_byte <= 1'b1;
								state <= mpc_pkg::MPC_RD_DATA;
							end
						end
					end
					default: state <= mpc_pkg::MPC_IDLE;
				endcase
			end
		end
	end

	// ****************************************************************
	// register storage
	// ****************************************************************
	// committed words hold until the next write or reset
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tach_resistance_setup <= mpc_pkg::TACH_RES_RST;
			motor_constant_advance_setup <= mpc_pkg::CONST_ADV_RST;
			startup_brake_setup <= mpc_pkg::START_BRAKE_RST;
		end else if (wr_stb) begin
			case (ptr)
				mpc_pkg::TACH_RES_OFS: tach_resistance_setup <= wr_word;
				mpc_pkg::CONST_ADV_OFS: motor_constant_advance_setup <= wr_word & mpc_pkg::CONST_ADV_WMASK;
				mpc_pkg::START_BRAKE_OFS: startup_brake_setup <= wr_word;
				default: ;
			endcase
		end
	end

	// ****************************************************************
	// operating values for the motor core
	// ****************************************************************
	// shadow select picks host values over nonvolatile ones
	assign op_tach_res = shadow_select ? tach_resistance_setup : nv_tach_res;
	assign op_const_adv = shadow_select ? motor_constant_advance_setup : (nv_const_adv & mpc_pkg::CONST_ADV_WMASK);
	assign op_start_brake = shadow_select ? startup_brake_setup : nv_start_brake;

	// decoded fields, mantissas shifted by their counts
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			spread_dither_select <= 2'h0;
			dither_span_pct <= mpc_pkg::DITHER_PCT_0;
			cycle_adjust_select <= 1'b0;
			phase_res_code <= 11'h000;
			bemf_const_code <= 11'h000;
			advance_mode <= 1'b0;
			startup_brake_setup_out <= 16'h0000;
		end else begin
			spread_dither_select <= op_tach_res[mpc_pkg::DITHER_LSB +: 2];
			case (op_tach_res[mpc_pkg::DITHER_LSB +: 2])
				2'h0: dither_span_pct <= mpc_pkg::DITHER_PCT_0;
				2'h1: dither_span_pct <= mpc_pkg::DITHER_PCT_1;
				2'h2: dither_span_pct <= mpc_pkg::DITHER_PCT_2;
				default: dither_span_pct <= mpc_pkg::DITHER_PCT_3;
			endcase
			cycle_adjust_select <= op_tach_res[mpc_pkg::CYCLE_ADJ_BIT];
			phase_res_code <= 11'(op_tach_res[mpc_pkg::RES_MANT_LSB +: 4]) << op_tach_res[mpc_pkg::RES_SHIFT_LSB +: 3];
			bemf_const_code <= 11'(op_const_adv[mpc_pkg::KT_MANT_LSB +: 4]) << op_const_adv[mpc_pkg::KT_SHIFT_LSB +: 3];
			advance_mode <= op_const_adv[mpc_pkg::ADV_MODE_BIT];
			startup_brake_setup_out <= op_start_brake;
		end
	end

	// ****************************************************************
	// commutation advance time
	// ****************************************************************
	logic [10:0] adv_base;
	logic [VW+10:0] adv_prod;
	logic [VW+10:0] adv_scaled;

	assign adv_base = 11'(op_const_adv[mpc_pkg::ADV_MANT_LSB +: 4]) << op_const_adv[mpc_pkg::ADV_SHIFT_LSB +: 3];
	assign adv_prod = (VW + 11)'(adv_base) * (VW + 11)'(bemf_voltage);
	assign adv_scaled = adv_prod / (VW + 11)'(supply_voltage);

	// fixed or supply-scaled advance; zero supply keeps the fixed value
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			advance_time <= 11'h000;
		end else if (!op_const_adv[mpc_pkg::ADV_MODE_BIT] || supply_voltage == '0) begin
			advance_time <= adv_base;
		end else if (adv_scaled > (VW + 11)'(11'h7FF)) begin
			advance_time <= 11'h7FF;
		end else begin
			advance_time <= adv_scaled[10:0];
		end
	end

	// ****************************************************************
	// tach output
	// ****************************************************************
	mpc_tach_gen #(
		.DELAY_CYCLES(TACH_DELAY_CYCLES)
	) u_tach (
		.clk(clk),
		.sys_rst(sys_rst),
		.elec_phase(elec_phase),
		.closed_loop(closed_loop),
		.first_openloop(first_openloop),
		.tach_openloop_select(op_tach_res[mpc_pkg::TACH_SEL_LSB +: 2]),
		.tach_pole_divider(op_tach_res[mpc_pkg::POLE_DIV_LSB +: 4]),
		.tach_output(tach_output)
	);
endmodule // mpc_config_regs
`default_nettype wire

/* File: dv/mpc_host.sv */
/*
 * Host model of the two-wire register port: start, stop, byte transfers
 * and whole register write and read cycles.
 * Assumes the bench forms the wire from sda_low and the device's pull-down
 * with a pull-up, and feeds that level back on sda.
 */
`timescale 1ns/1ps
`default_nettype none
module mpc_host #(
	parameter logic [6:0] ADDR = mpc_pkg::DEV_ADDR_DEFAULT
) (
	input wire logic clk,
	input wire logic sda,
	output logic scl,
	output logic sda_low
);
	// ****************************************************************
	// bus phases, each four clocks long, changed on the falling edge
	// ****************************************************************
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	task automatic wt();
		repeat (4) @(negedge clk);
	endtask

	// start or repeated start: sda falls while scl is high
	task automatic start();
		sda_low = 1'b0;
		wt();
		scl = 1'b1;
		wt();
		sda_low = 1'b1;
		wt();
		scl = 1'b0;
	endtask

	task automatic stop();
		sda_low = 1'b1;
		wt();
		scl = 1'b1;
		wt();
		sda_low = 1'b0;
		wt();
	endtask

	// one bit: data set while scl is low, sampled at the end of scl high
	task automatic bit_x(input logic b, output logic r);
		sda_low = !b;
		wt();
		scl = 1'b1;
		wt();
		r = sda;
		scl = 1'b0;
	endtask

	// eight bits high first, then the acknowledge bit
	task automatic xfer(input logic [7:0] d, input logic ack_in,
		output logic [7:0] q, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], q[i]);
		end
		bit_x(ack_in, ack);
	endtask

	// reserved bits are written only where a scenario means it
	task automatic write_reg(input logic [7:0] p, input logic [15:0] d,
		output logic ok);
		logic [7:0] q;
		logic a0, a1, a2, a3;
		start();
		xfer({ADDR, 1'b0}, 1'b1, q, a0);
		xfer(p, 1'b1, q, a1);
		xfer(d[15:8], 1'b1, q, a2);
		xfer(d[7:0], 1'b1, q, a3);
		stop();
		ok = !(a0 | a1 | a2 | a3);
	endtask

	// pointer write, repeated start, two bytes read, last one refused
	task automatic read_reg(input logic [7:0] p, output logic [15:0] d,
		output logic ok);
		logic [7:0] q;
		logic a0, a1, a2, a3;
		start();
		xfer({ADDR, 1'b0}, 1'b1, q, a0);
		xfer(p, 1'b1, q, a1);
		start();
		xfer({ADDR, 1'b1}, 1'b1, q, a2);
		xfer(8'hFF, 1'b0, d[15:8], a3);
		xfer(8'hFF, 1'b1, d[7:0], a3);
		stop();
		ok = !(a0 | a1 | a2);
	endtask
endmodule // mpc_host
`default_nettype wire

/* File: dv/mpc_config_regs_sva.sv */
/*
 * Checker of the configuration bank: decoded fields against their sources,
 * tach gating and reset state.
 * Assumes it is bound to the design and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none
module mpc_config_regs_sva (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic sda_oe,
	input wire logic shadow_select,
	input wire logic [15:0] nv_tach_res,
	input wire logic [15:0] nv_const_adv,
	input wire logic [15:0] nv_start_brake,
	input wire logic closed_loop,
	input wire logic tach_output,
	input wire logic [1:0] spread_dither_select,
	input wire logic [4:0] dither_span_pct,
	input wire logic cycle_adjust_select,
	input wire logic [10:0] phase_res_code,
	input wire logic [10:0] bemf_const_code,
	input wire logic [10:0] advance_time,
	input wire logic [15:0] startup_brake_setup_out
);
	// ****************************************************************
	// sources one clock back, valid only outside reset
	// ****************************************************************
	logic [15:0] p_res, p_cst, p_brk;
	logic p_sel, p_rst, ok_nv;

	// delayed copies, since outputs lag their source by one clock
	always_ff @(posedge clk) begin
		p_res <= nv_tach_res;
		p_cst <= nv_const_adv;
		p_brk <= nv_start_brake;
		p_sel <= shadow_select;
		p_rst <= sys_rst;
	end

	assign ok_nv = !p_rst && !p_sel;

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	// ****************************************************************
	// assertions
	// ****************************************************************
	dither_span_a:
	assert property (dither_span_pct == (spread_dither_select == 2'h0 ? 5'h00
		: spread_dither_select == 2'h1 ? 5'h05
		: spread_dither_select == 2'h2 ? 5'h0A : 5'h0F))
		else $error("dither span does not match its code");
	res_code_a:
	assert property (ok_nv |-> phase_res_code == (11'(p_res[3:0]) << p_res[6:4]))
		else $error("resistance code wrong");
	bemf_code_a:
	assert property (ok_nv |-> bemf_const_code == (11'(p_cst[11:8]) << p_cst[14:12]))
		else $error("back-emf constant wrong");
	fixed_adv_a:
	assert property (ok_nv && !p_cst[7] |->
		advance_time == (11'(p_cst[3:0]) << p_cst[6:4]))
		else $error("fixed advance time wrong");
	nv_fields_a:
	assert property (ok_nv |-> cycle_adjust_select == p_res[7]
		&& spread_dither_select == p_res[15:14] && startup_brake_setup_out == p_brk)
		else $error("field copy wrong");
	tach_off_a:
	assert property ((!shadow_select && nv_tach_res[13:12] == 2'h3)[*4]
		|-> !tach_output)
		else $error("tach active on reserved code");
	tach_wait_a:
	assert property ((!shadow_select && nv_tach_res[13:12] == 2'h1
		&& !closed_loop)[*4] |-> !tach_output)
		else $error("tach active in open loop");
	reset_zero_a:
	assert property ($fell(sys_rst) |-> !sda_oe && !tach_output
		&& phase_res_code == 11'h000 && advance_time == 11'h000)
		else $error("outputs not cleared by reset");
endmodule // mpc_config_regs_sva

bind mpc_config_regs mpc_config_regs_sva u_mpc_config_regs_sva (
	.clk(clk), .sys_rst(sys_rst), .sda_oe(sda_oe),
	.shadow_select(shadow_select), .nv_tach_res(nv_tach_res),
	.nv_const_adv(nv_const_adv), .nv_start_brake(nv_start_brake),
	.closed_loop(closed_loop), .tach_output(tach_output),
	.spread_dither_select(spread_dither_select),
	.dither_span_pct(dither_span_pct),
	.cycle_adjust_select(cycle_adjust_select),
	.phase_res_code(phase_res_code), .bemf_const_code(bemf_const_code),
	.advance_time(advance_time),
	.startup_brake_setup_out(startup_brake_setup_out)
);
`default_nettype wire

/* File: dv/tb_mpc_config_regs.sv */
/*
 * Testbench of the configuration bank: register traffic through the host
 * model, decoded fields, scaled advance and tach gating.
 * Assumes the checker is bound from its own file.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_mpc_config_regs;
	// rows: code, closed loop, first open loop, expected tach toggles
	localparam logic [55:0] TACH_ROWS = 56'h809464402404F0;
	logic clk, sys_rst, sda, scl, host_low, dev_low, ok;
	logic shadow_select, elec_phase, closed_loop, first_openloop;
	logic [15:0] nv_tach_res, nv_const_adv, nv_start_brake, brk_out, rd;
	logic [9:0] bemf_voltage, supply_voltage;
	logic tach_output, cycle_adjust_select, advance_mode;
	logic [1:0] spread_dither_select;
	logic [4:0] dither_span_pct;
	logic [10:0] phase_res_code, bemf_const_code, advance_time;
	int n_mismatch, total_checks;

	// open-drain wire with pull-up
	assign sda = !(host_low || dev_low);

	mpc_config_regs #(.TACH_DELAY_CYCLES(20)) u_mpc_config_regs (
		.clk(clk), .sys_rst(sys_rst), .scl(scl), .sda_in(sda), .sda_out(),
		.sda_oe(dev_low), .shadow_select(shadow_select),
		.nv_tach_res(nv_tach_res), .nv_const_adv(nv_const_adv),
		.nv_start_brake(nv_start_brake), .elec_phase(elec_phase),
		.closed_loop(closed_loop), .first_openloop(first_openloop),
		.bemf_voltage(bemf_voltage), .supply_voltage(supply_voltage),
		.tach_output(tach_output), .spread_dither_select(spread_dither_select),
		.dither_span_pct(dither_span_pct),
		.cycle_adjust_select(cycle_adjust_select),
		.phase_res_code(phase_res_code), .bemf_const_code(bemf_const_code),
		.advance_mode(advance_mode), .advance_time(advance_time),
		.startup_brake_setup_out(brk_out));
	mpc_host u_mpc_host (.clk(clk), .sda(sda), .scl(scl), .sda_low(host_low));

	// ****************************************************************
	// clock, watchdog and shared tasks
	// ****************************************************************
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// cuts a hang short after about eight times the expected run
	initial begin
		repeat (60000) @(posedge clk);
		n_mismatch++;
		finish_test();
	end

	task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", what, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] p, input logic [15:0] d);
		u_mpc_host.write_reg(p, d, ok);
		chk("write ack", 16'h0001, 16'(ok));
	endtask

	task automatic rdc(input logic [7:0] p, input logic [15:0] e);
		u_mpc_host.read_reg(p, rd, ok);
		chk("read ack", 16'h0001, 16'(ok));
		chk("read data", e, rd);
	endtask

	task automatic finish_test();
		$display("checks %0d, mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic t_reset();
		rdc(mpc_pkg::TACH_RES_OFS, mpc_pkg::TACH_RES_RST);
		rdc(mpc_pkg::CONST_ADV_OFS, mpc_pkg::CONST_ADV_RST);
		rdc(mpc_pkg::START_BRAKE_OFS, mpc_pkg::START_BRAKE_RST);
	endtask

	// every dither code; 0.3 ohm is 30 counts, so mantissa 15, shift 1
	task automatic t_cfg1();
		logic [15:0] v;
		shadow_select = 1'b1;
		nv_tach_res = 16'hFFFF;
		for (int d = 0; d < 4; d++) begin
			v = {2'(d), 6'h00, 1'(d), 3'h1, 4'hF};
			wr(mpc_pkg::TACH_RES_OFS, v);
			repeat (4) @(negedge clk);
			chk("dither", 16'(d), 16'(spread_dither_select));
			chk("span", 16'(5 * d), 16'(dither_span_pct));
			chk("cycle adj", 16'(d & 1), 16'(cycle_adjust_select));
			chk("res code", 16'h001E, 16'(phase_res_code));
			rdc(mpc_pkg::TACH_RES_OFS, v);
		end
	endtask

	// reserved bit written, scaled then fixed advance
	task automatic t_cfg2();
		wr(mpc_pkg::CONST_ADV_OFS, 16'hFFFF);
		rdc(mpc_pkg::CONST_ADV_OFS, 16'h7FFF);
		chk("bemf code", 16'h0780, 16'(bemf_const_code));
		chk("adv mode", 16'h0001, 16'(advance_mode));
		chk("adv time", 16'h0780, 16'(advance_time));
		bemf_voltage = 10'd200;
		repeat (40) @(negedge clk);
		chk("adv scaled", 16'h03C0, 16'(advance_time));
		wr(mpc_pkg::CONST_ADV_OFS, 16'h0F25);
		repeat (4) @(negedge clk);
		chk("bemf code", 16'h000F, 16'(bemf_const_code));
		chk("adv mode", 16'h0000, 16'(advance_mode));
		chk("adv time", 16'h0014, 16'(advance_time));
	endtask

	// third register, unmapped pointer, earlier value kept
	task automatic t_other();
		wr(mpc_pkg::START_BRAKE_OFS, 16'hA55A);
		rdc(mpc_pkg::START_BRAKE_OFS, 16'hA55A);
		chk("brake copy", 16'hA55A, brk_out);
		wr(8'h93, 16'h1234);
		rdc(8'h93, 16'h0000);
		rdc(mpc_pkg::TACH_RES_OFS, 16'hC09F);
	endtask

	// tach gating by code and loop phase, divide by three
	task automatic t_tach();
		logic [7:0] row;
		logic [15:0] n;
		logic last;
		shadow_select = 1'b0;
		for (int i = 0; i < 7; i++) begin
			row = TACH_ROWS[8 * i +: 8];
			nv_tach_res = {2'h0, row[7:6], 4'h2, 8'h00};
			closed_loop = row[5];
			first_openloop = row[4];
			repeat (30) @(negedge clk);
			n = 16'h0000;
			for (int e = 0; e < 12; e++) begin
				elec_phase = !elec_phase;
				repeat (4) begin
					last = tach_output;
					@(negedge clk);
					n += 16'(tach_output !== last);
				end
			end
			chk("tach toggles", 16'(row[3:0]), n);
		end
	endtask

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		sys_rst = 1'b1;
		shadow_select = 1'b0;
		nv_tach_res = 16'h0000;
		nv_const_adv = 16'h3A52;
		nv_start_brake = 16'h0000;
		elec_phase = 1'b0;
		closed_loop = 1'b0;
		first_openloop = 1'b0;
		bemf_voltage = 10'd400;
		supply_voltage = 10'd400;
		n_mismatch = 0;
		total_checks = 0;
		repeat (16) @(negedge clk);
		sys_rst = 1'b0;
		@(negedge clk);
		t_reset();
		t_cfg1();
		t_cfg2();
		t_other();
		t_tach();
		finish_test();
	end
endmodule // tb_mpc_config_regs
`default_nettype wire
